/* File: rtl/monitor_channel_handshake.sv */
// Decided for this implementation: strobed register access and the placing of the registers.
`timescale 1ns/1ps
`default_nettype none
module monitor_channel_handshake
	import monitor_pkg::*;
(
	input  wire logic       sys_clk,
	input  wire logic       srst,
	input  wire logic [2:0] addr,
	input  wire logic [7:0] wr_data,
	input  wire logic       wr_en,
	input  wire logic       rd_en,
	output logic      [7:0] rd_data,
	input  wire logic       dcl,
	input  wire logic       fsc,
	input  wire logic       du_in,
	output logic            du_out,
	output logic            du_oe,
	input  wire logic       dd_in,
	output logic            dd_out,
	output logic            dd_oe
);
	//----------------------------------------
	// declarations
	//----------------------------------------
	logic [3:0] pins_s;
	logic [6:0] bit_idx;
	logic       drive_tick;
	logic       sample_tick;
	logic [7:0] ctrl_q;
	logic [7:0] hs_q;
	logic [7:0] cfg_q;
	logic [3:0] status_q;
	logic [3:0] status_set;
	logic [7:0] tx_byte_q;
	logic [7:0] rx_byte_q;
	logic [7:0] rd_data_q;
	logic [7:0] rd_mux;
	logic       mac_q;
	logic       du_oe_q;
	logic       dd_oe_q;
	logic       drv_exp_q;
	logic       chk_q;
	logic       coll_q;
	logic [7:0] rx_shift_q;
	logic [7:0] rx_prev_q;
	logic       mx_in_q;
	logic       mx_prev_q;
	logic       mr_in_q;
	logic       mr_prev_q;
	logic       mx_out_q;
	logic       mr_out_q;
	tx_state_t  tx_q;
	tx_state_t  tx_d;
	logic [5:0] timer_q;
	logic [1:0] eom_cnt_q;
	logic       acked_q;
	logic       new_byte_q;
	logic       taken_q;
	logic       rx_busy_q;
	logic       ack_en_q;
	logic       await_q;
	logic       read_seen_q;

	//----------------------------------------
	// pin sampling and bit timing
	//----------------------------------------
	pin_sync #(.WIDTH(4)) u_sync (
		.async_in (({dcl, fsc, du_in, dd_in})),
		.sys_clk  (sys_clk),
		.srst     (srst),
		.sync_out (pins_s)
	);

	frame_slot_counter u_slots (
		.sys_clk     (sys_clk),
		.srst        (srst),
		.dcl_s       (pins_s[3]),
		.fsc_s       (pins_s[2]),
		.bit_idx     (bit_idx),
		.drive_tick  (drive_tick),
		.sample_tick (sample_tick)
	);

	function automatic logic [6:0] slot_pos(input logic [1:0] ch, input logic [6:0] ofs);
		return {ch, 5'h00} + ofs;
	endfunction

	//----------------------------------------
	// slot decode and line selection
	//----------------------------------------
	logic [6:0] mon_base;
	logic [6:0] mon_end;
	logic [6:0] mx_pos;
	logic [6:0] mr_pos;
	logic [2:0] mon_bit;
	logic       in_mon;
	logic       at_mx;
	logic       at_mr;
	logic       data_port_select;
	logic       mon_en;
	logic       line_in;
	logic       line_out_s;
	logic       tx_on;
	logic       drv_val;
	logic       drive_low;
	logic       coll_now;
	logic       frame_tick;

	// selected channel places the monitor byte and handshake bits
	assign mon_base   = slot_pos(ctrl_q[1:0], MON_OFS);
	assign mon_end    = mon_base + MON_LEN;
	assign mx_pos     = slot_pos(ctrl_q[1:0], MX_OFS);
	assign mr_pos     = slot_pos(ctrl_q[1:0], MR_OFS);
	assign mon_bit    = 3'(bit_idx - mon_base);
	assign in_mon     = (bit_idx >= mon_base) && (bit_idx < mon_end);
	assign at_mx      = bit_idx == mx_pos;
	assign at_mr      = bit_idx == mr_pos;
	// port select: 0 sends downstream and listens upstream
	assign data_port_select        = ctrl_q[CTRL_DPS];
	assign mon_en     = ctrl_q[CTRL_EN];
	assign line_in    = data_port_select ? pins_s[0] : pins_s[1];
	assign line_out_s = data_port_select ? pins_s[1] : pins_s[0];
	assign frame_tick = drive_tick && (bit_idx == BIT_FIRST);

	// value owed on the line for the current bit, msb first
	assign tx_on     = tx_q != TX_IDLE;
	assign drv_val   = (in_mon && tx_on) ? tx_byte_q[~mon_bit] :
	                   at_mx ? mx_out_q : at_mr ? mr_out_q : HS_INACTIVE;
	assign drive_low = mon_en && !drv_val;
	// released bit read back low means another driver
	assign coll_now  = sample_tick && chk_q && drv_exp_q && !line_out_s;

	//----------------------------------------
	// line drive, open drain
	//----------------------------------------
	always_ff @(posedge sys_clk) begin
		if (srst) begin
			du_oe_q   <= 1'b0;
			dd_oe_q   <= 1'b0;
			drv_exp_q <= 1'b1;
			chk_q     <= 1'b0;
		end else if (drive_tick) begin
			du_oe_q   <= data_port_select && drive_low;
			dd_oe_q   <= !data_port_select && drive_low;
			drv_exp_q <= drv_val;
			chk_q     <= mon_en && tx_on && (in_mon || at_mx);
		end
	end

	//----------------------------------------
	// bit capture within the frame
	//----------------------------------------
	always_ff @(posedge sys_clk) begin
		if (srst) begin
			rx_shift_q <= 8'h00;
			mx_in_q    <= HS_INACTIVE;
			mr_in_q    <= HS_INACTIVE;
			coll_q     <= 1'b0;
		end else begin
			if (sample_tick && in_mon) begin
				rx_shift_q <= {rx_shift_q[6:0], line_in};
			end
			if (sample_tick && at_mx) begin
				mx_in_q <= line_in;
			end
			if (sample_tick && at_mr) begin
				mr_in_q <= line_in;
			end
			coll_q <= coll_now || (coll_q && !frame_tick);
		end
	end

	//----------------------------------------
	// transmitter
	//----------------------------------------
	logic mr_ack;
	logic mr_abort;
	logic timeout_enable_hit;
	logic abort_tx;
	logic consume;

	// acknowledge is receive handshake going inactive to active
	assign mr_ack   = mr_prev_q && !mr_in_q;
	assign mr_abort = acked_q && mr_prev_q && mr_in_q;
	assign timeout_enable_hit = cfg_q[CFG_TIMEOUT_ENABLE] && (timer_q == TIMEOUT_FRAMES);
	assign abort_tx = coll_q || mr_abort || timeout_enable_hit;
	assign consume  = frame_tick && ((tx_q == TX_HOLD && tx_d == TX_GAP) || tx_q == TX_IDLE);

	// next state once per frame
	always_comb begin
		tx_d = tx_q;
		unique case (tx_q)
			TX_IDLE: begin
				if (hs_q[HS_MXC]) begin
					tx_d = TX_SEND;
				end
			end
			TX_SEND: begin
				if (!hs_q[HS_MXC] || abort_tx) begin
					tx_d = TX_EOM;
				end else if (mr_ack) begin
					tx_d = TX_HOLD;
				end
			end
			TX_HOLD: begin
				// both handshakes active: the byte is resent as a delay
				if (!hs_q[HS_MXC] || abort_tx) begin
					tx_d = TX_EOM;
				end else if (new_byte_q) begin
					tx_d = TX_GAP;
				end
			end
			TX_GAP: begin
				tx_d = abort_tx ? TX_EOM : TX_SEND;
			end
			TX_EOM: begin
				if (eom_cnt_q == EOM_LAST) begin
					tx_d = TX_IDLE;
				end
			end
		endcase
	end

	// state, handshake bit and waiting timer
	always_ff @(posedge sys_clk) begin
		if (srst) begin
			tx_q      <= TX_IDLE;
			mx_out_q  <= HS_INACTIVE;
			timer_q   <= 6'h00;
			eom_cnt_q <= 2'h0;
			acked_q   <= 1'b0;
			mac_q     <= 1'b0;
		end else if (frame_tick) begin
			tx_q      <= tx_d;
			// same byte repeats while handshake stays active
			mx_out_q  <= (tx_d == TX_SEND || tx_d == TX_HOLD) ? HS_ACTIVE : HS_INACTIVE;
			timer_q   <= (tx_d != tx_q || tx_d == TX_GAP) ? 6'h00 : timer_q + 6'h01;
			eom_cnt_q <= (tx_q == TX_EOM) ? eom_cnt_q + 2'h1 : 2'h0;
			acked_q   <= (tx_d != TX_IDLE) && (acked_q || (tx_q == TX_SEND && mr_ack));
			mac_q     <= (tx_d != TX_IDLE) || (mr_in_q == HS_ACTIVE);
		end
	end

	//----------------------------------------
	// receiver
	//----------------------------------------
	logic rx_valid;
	logic rx_eom;
	logic pulse_now;
	logic ack_en_d;
	logic rx_busy_d;

	// two identical frames with handshake active make a byte
	assign rx_valid  = !mx_in_q && !mx_prev_q && (rx_shift_q == rx_prev_q) && !taken_q;
	assign rx_eom    = mx_in_q && mx_prev_q && rx_busy_q;
	assign pulse_now = await_q && read_seen_q;
	assign ack_en_d  = hs_q[HS_MRC] && (ack_en_q || rx_valid || rx_busy_q);
	assign rx_busy_d = rx_valid || (rx_busy_q && !rx_eom);

	always_ff @(posedge sys_clk) begin
		if (srst) begin
			rx_prev_q <= 8'h00;
			rx_byte_q <= 8'h00;
			mx_prev_q <= HS_INACTIVE;
			mr_prev_q <= HS_INACTIVE;
			mr_out_q  <= HS_INACTIVE;
			taken_q   <= 1'b0;
			rx_busy_q <= 1'b0;
			ack_en_q  <= 1'b0;
			await_q   <= 1'b0;
		end else if (frame_tick) begin
			rx_prev_q <= rx_shift_q;
			mx_prev_q <= mx_in_q;
			mr_prev_q <= mr_in_q;
			taken_q   <= !mx_in_q && (taken_q || rx_valid);
			rx_busy_q <= rx_busy_d;
			ack_en_q  <= ack_en_d;
			// stored as plain data, never decoded as a command
			if (rx_valid) begin
				rx_byte_q <= rx_shift_q;
			end
			await_q   <= hs_q[HS_MRC] && !pulse_now && (await_q || (rx_valid && rx_busy_q));
			mr_out_q  <= (ack_en_d && !pulse_now) ? HS_ACTIVE : HS_INACTIVE;
		end
	end

	//----------------------------------------
	// status events and register port
	//----------------------------------------
	logic wr_ctrl;
	logic wr_hs;
	logic wr_txb;
	logic wr_cfg;
	logic rd_stat;
	logic rd_rxb;

	assign wr_ctrl = wr_en && addr == ADDR_CTRL;
	assign wr_hs   = wr_en && addr == ADDR_HS;
	assign wr_txb  = wr_en && addr == ADDR_TXB;
	assign wr_cfg  = wr_en && addr == ADDR_CFG;
	assign rd_stat = rd_en && addr == ADDR_STAT;
	assign rd_rxb  = rd_en && addr == ADDR_RXB;

	// enables gate the events before they reach the sticky bits
	assign status_set[ST_MDA] = frame_tick && hs_q[HS_MIE] && tx_q == TX_SEND && mr_ack && !abort_tx;
	assign status_set[ST_MAB] = frame_tick && hs_q[HS_MIE] && tx_on && tx_q != TX_EOM && abort_tx;
	assign status_set[ST_MDR] = frame_tick && hs_q[HS_MRE] && rx_valid && (hs_q[HS_MRC] || !rx_busy_q);
	assign status_set[ST_MER] = frame_tick && hs_q[HS_MIE] && rx_eom;

	always_comb begin
		unique case (addr)
			ADDR_CTRL:  rd_mux = ctrl_q;
			ADDR_HS:    rd_mux = hs_q;
			ADDR_STAT:  rd_mux = {4'h0, status_q};
			ADDR_STATE: rd_mux = {7'h00, mac_q};
			ADDR_TXB:   rd_mux = tx_byte_q;
			ADDR_RXB:   rd_mux = rx_byte_q;
			ADDR_CFG:   rd_mux = cfg_q;
			default:    rd_mux = 8'h00;
		endcase
	end

	// registers; status clears on read, a new event wins
	always_ff @(posedge sys_clk) begin
		if (srst) begin
			ctrl_q      <= CTRL_RST;
			hs_q        <= HS_RST;
			cfg_q       <= CFG_RST;
			status_q    <= 4'h0;
			tx_byte_q   <= 8'h00;
			rd_data_q   <= 8'h00;
			new_byte_q  <= 1'b0;
			read_seen_q <= 1'b0;
		end else begin
			if (wr_ctrl) begin
				ctrl_q <= wr_data & CTRL_MASK;
			end
			if (wr_hs) begin
				hs_q <= wr_data & HS_MASK;
			end
			if (wr_cfg) begin
				cfg_q <= wr_data & CFG_MASK;
			end
			if (wr_txb) begin
				tx_byte_q <= wr_data;
			end
			status_q    <= (status_q & ~{4{rd_stat}}) | status_set;
			rd_data_q   <= rd_en ? rd_mux : 8'h00;
			new_byte_q  <= wr_txb || (new_byte_q && !consume);
			read_seen_q <= rd_rxb || (read_seen_q && !(frame_tick && (pulse_now || rx_valid)));
		end
	end

	assign rd_data = rd_data_q;
	assign du_out  = 1'b0;
	assign dd_out  = 1'b0;
	assign du_oe   = du_oe_q;
	assign dd_oe   = dd_oe_q;

	//----------------------------------------
	// assertions
	//----------------------------------------
	default clocking cb @(posedge sys_clk); endclocking
	default disable iff (srst);

	sequence s_gap_frame;
		frame_tick && tx_q == TX_GAP && !abort_tx;
	endsequence
	sequence s_eom_start;
		frame_tick && tx_q != TX_EOM && tx_d == TX_EOM;
	endsequence

	a_reset_defaults: assert property ($fell(srst) |-> ctrl_q == CTRL_RST)
		else $error("control register not at reset value");
	a_gap_one_frame: assert property (s_gap_frame |=> tx_q == TX_SEND && mx_out_q == HS_ACTIVE)
		else $error("gap frame not followed by active handshake");
	a_eom_inactive: assert property (s_eom_start |=> mx_out_q == HS_INACTIVE [*8])
		else $error("handshake not inactive at end of message");
	a_timeout_abort: assert property (frame_tick && timeout_enable_hit && tx_q == TX_SEND |=> tx_q == TX_EOM)
		else $error("timeout did not abort");
	a_collision_abort: assert property (frame_tick && coll_q && tx_on && tx_q != TX_EOM |=> tx_q == TX_EOM)
		else $error("collision did not abort");
	a_mr_forced: assert property (frame_tick && !hs_q[HS_MRC] |=> mr_out_q == HS_INACTIVE)
		else $error("receive handshake active without control");
	a_mdr_gate: assert property ($rose(status_q[ST_MDR]) |-> $past(hs_q[HS_MRE]))
		else $error("data received status without enable");
	a_mer_gate: assert property ($rose(status_q[ST_MER]) |-> $past(hs_q[HS_MIE]))
		else $error("end of reception status without enable");
	a_rx_store: assert property (frame_tick && rx_valid |=> rx_byte_q == $past(rx_shift_q))
		else $error("valid byte not stored");
	a_read_latency: assert property (rd_en && addr == ADDR_RXB |=> rd_data_q == $past(rx_byte_q))
		else $error("receive byte read data wrong");
	a_idle_release: assert property (tx_q == TX_IDLE |-> mx_out_q == HS_INACTIVE)
		else $error("transmit handshake active while idle");
endmodule
`default_nettype wire

/* File: rtl/monitor_pkg.sv */
// Function
// - monitor data rides the selected of three channels
// - port select picks line, enable gates drive
// - reset gives channel 0, enabled, downstream line
// - same byte resent each frame until acknowledged
// - transmit control set drives transmit handshake active
// - valid byte stored, data received status raised
// - receive control set acknowledges first byte
// - new byte: transmit handshake inactive one frame
// - receive byte read: handshake inactive one frame
// - transmit control clear ends message, receiver flags
// - receive control clear ends transfer, active drops
// - receive handshake inactive twice means abort request
// - both handshakes inactive twice means idle
// - accept byte only after two identical frames
// - check every driven data bit and the transmit handshake bit
// - transmit and receive run at once
// - common enable gates acknowledge, abort, end statuses
// - receive enable gates data received status
// - no legacy numbered monitor commands, interrupts only
// - timeout aborts after forty frames, then end
// - own transmit aborts on abort request, collision, timeout
package monitor_pkg;

	//----------------------------------------
	// frame layout
	//----------------------------------------
	localparam logic [6:0] BIT_FIRST = 7'h00;
	localparam logic [6:0] BIT_LAST  = 7'h5F;
	localparam logic [6:0] BIT_STEP  = 7'h01;
	localparam logic [6:0] MON_OFS   = 7'h10; // monitor byte in channel
	localparam logic [6:0] MON_LEN   = 7'h08;
	localparam logic [6:0] MR_OFS    = 7'h1E; // receive handshake bit
	localparam logic [6:0] MX_OFS    = 7'h1F; // transmit handshake bit
	localparam logic       HS_ACTIVE   = 1'b0;
	localparam logic       HS_INACTIVE = 1'b1;

	//----------------------------------------
	// register map and fields
	//----------------------------------------
	localparam logic [2:0] ADDR_CTRL  = 3'h0;
	localparam logic [2:0] ADDR_HS    = 3'h1;
	localparam logic [2:0] ADDR_STAT  = 3'h2;
	localparam logic [2:0] ADDR_STATE = 3'h3;
	localparam logic [2:0] ADDR_TXB   = 3'h4;
	localparam logic [2:0] ADDR_RXB   = 3'h5;
	localparam logic [2:0] ADDR_CFG   = 3'h6;
	localparam logic [7:0] CTRL_RST   = 8'h08;
	localparam logic [7:0] CTRL_MASK  = 8'h0F;
	localparam logic [7:0] HS_RST     = 8'h00;
	localparam logic [7:0] HS_MASK    = 8'h0F;
	localparam logic [7:0] CFG_RST    = 8'h00;
	localparam logic [7:0] CFG_MASK   = 8'h01;
	localparam int CTRL_DPS = 2;
	localparam int CTRL_EN  = 3;
	localparam int HS_MXC   = 0;
	localparam int HS_MIE   = 1;
	localparam int HS_MRC   = 2;
	localparam int HS_MRE   = 3;
	localparam int ST_MDA   = 0;
	localparam int ST_MAB   = 1;
	localparam int ST_MDR   = 2;
	localparam int ST_MER   = 3;
	localparam int CFG_TIMEOUT_ENABLE = 0;

	//----------------------------------------
	// timing
	//----------------------------------------
	localparam int unsigned TIMEOUT_MS = 5;
	localparam int unsigned FRAME_US   = 125;
	localparam logic [5:0]  TIMEOUT_FRAMES = 6'(TIMEOUT_MS * 1000 / FRAME_US);
	localparam logic [1:0]  EOM_LAST   = 2'h1; // two inactive frames

	typedef enum logic [2:0] {TX_IDLE, TX_SEND, TX_HOLD, TX_GAP, TX_EOM} tx_state_t;

endpackage

/* File: rtl/pin_sync.sv */
`timescale 1ns/1ps
`default_nettype none
module pin_sync #(
	parameter int unsigned WIDTH = 4
) (
	input  wire logic [WIDTH-1:0] async_in,
	input  wire logic             sys_clk,
	input  wire logic             srst,
	output logic      [WIDTH-1:0] sync_out
);
	logic [WIDTH-1:0] s1_q;
	logic [WIDTH-1:0] s2_q;
	logic [WIDTH-1:0] s3_q;
	logic [WIDTH-1:0] out_q;

	// three stages, output moves once stages two and three agree
	always_ff @(posedge sys_clk) begin
		if (srst) begin
			s1_q  <= '0;
			s2_q  <= '0;
			s3_q  <= '0;
			out_q <= '0;
		end else begin
			s1_q  <= async_in;
			s2_q  <= s1_q;
			s3_q  <= s2_q;
			out_q <= (s2_q & s3_q) | (out_q & (s2_q | s3_q));
		end
	end

	assign sync_out = out_q;
endmodule
`default_nettype wire

/* File: rtl/frame_slot_counter.sv */
`timescale 1ns/1ps
`default_nettype none
module frame_slot_counter
	import monitor_pkg::*;
(
	input  wire logic       sys_clk,
	input  wire logic       srst,
	input  wire logic       dcl_s,
	input  wire logic       fsc_s,
	output logic      [6:0] bit_idx,
	output logic            drive_tick,
	output logic            sample_tick
);
	logic       dcl_prev_q;
	logic [6:0] idx_q;
	logic       drv_q;
	logic       smp_q;
	logic       dcl_rise;
	logic       dcl_fall;
	logic [6:0] idx_d;

	// edges of the data clock, bit index moves on falling edge
	assign dcl_rise = dcl_s & ~dcl_prev_q;
	assign dcl_fall = ~dcl_s & dcl_prev_q;
	assign idx_d    = (fsc_s || idx_q == BIT_LAST) ? BIT_FIRST : idx_q + BIT_STEP;

	always_ff @(posedge sys_clk) begin
		if (srst) begin
			dcl_prev_q <= 1'b0;
			idx_q      <= BIT_LAST;
			drv_q      <= 1'b0;
			smp_q      <= 1'b0;
		end else begin
			dcl_prev_q <= dcl_s;
			drv_q      <= dcl_fall;
			smp_q      <= dcl_rise;
			if (dcl_fall) begin
				idx_q <= idx_d;
			end
		end
	end

	assign bit_idx     = idx_q;
	assign drive_tick  = drv_q;
	assign sample_tick = smp_q;
endmodule
`default_nettype wire

/* File: test/bus_partner.sv */
`timescale 1ns/1ps
`default_nettype none
module bus_partner (
	output var logic       dcl,
	output var logic       fsc,
	output var logic       du_low,
	output var logic       dd_low,
	input  wire logic      dd_w,
	input  wire logic [7:0] p_byte,
	input  wire logic      p_mx,
	input  wire logic      p_mr,
	input  wire logic      p_jam,
	output var logic [7:0] seen_byte,
	output var logic       seen_mx,
	output var logic       seen_mr
);
	logic [6:0] bit_n;
	logic [7:0] cap;

	// free-running bit clock, launch at fall, sample at rise
	initial begin
		dcl = 1'b1;
		fsc = 1'b1;
		du_low = 1'b0;
		dd_low = 1'b0;
		bit_n = 7'h00;
		cap = 8'hFF;
		seen_byte = 8'hFF;
		seen_mx = 1'b1;
		seen_mr = 1'b1;
		#3;
		forever begin
			#32 dcl = 1'b0;
			du_low = 1'b0;
			if (bit_n >= 7'h10 && bit_n < 7'h18)
				du_low = ~p_byte[3'(7'h17 - bit_n)];
			if (bit_n == 7'h1E)
				du_low = ~p_mr;
			if (bit_n == 7'h1F)
				du_low = ~p_mx;
			dd_low = p_jam && (bit_n == 7'h10); // forced clash on byte msb
			#32 dcl = 1'b1;
			if (bit_n >= 7'h10 && bit_n < 7'h18)
				cap = {cap[6:0], dd_w};
			if (bit_n == 7'h1E)
				seen_mr = dd_w;
			if (bit_n == 7'h1F) begin
				seen_mx = dd_w;
				seen_byte = cap;
			end
			bit_n = (bit_n == 7'h5F) ? 7'h00 : bit_n + 7'h01;
			fsc = (bit_n == 7'h00);
		end
	end
endmodule
`default_nettype wire

/* File: test/tb.sv */
`timescale 1ns/1ps
`default_nettype none
module tb
	import monitor_pkg::*;
;
	logic        sys_clk, srst, wr_en, rd_en, rd_seen, du_hit;
	logic [2:0]  addr;
	logic [7:0]  wr_data, rd_data, p_byte, seen_byte;
	logic        dcl, fsc, du_out, du_oe, dd_out, dd_oe;
	logic        du_w, dd_w, du_low, dd_low;
	logic        p_mx, p_mr, p_jam, seen_mx, seen_mr;
	logic [31:0] lfsr_q;
	logic [15:0] exp_q[$];
	logic [15:0] note;
	int          fail_count, n_checks, cycles;

	// open-drain lines with pull-up
	assign du_w = ~(du_oe | du_low);
	assign dd_w = ~(dd_oe | dd_low);

	monitor_channel_handshake u_dut (
		.sys_clk(sys_clk), .srst(srst), .addr(addr), .wr_data(wr_data), .wr_en(wr_en),
		.rd_en(rd_en), .rd_data(rd_data), .dcl(dcl), .fsc(fsc), .du_in(du_w),
		.du_out(du_out), .du_oe(du_oe), .dd_in(dd_w), .dd_out(dd_out), .dd_oe(dd_oe)
	);

	bus_partner u_partner (
		.dcl(dcl), .fsc(fsc), .du_low(du_low), .dd_low(dd_low), .dd_w(dd_w),
		.p_byte(p_byte), .p_mx(p_mx), .p_mr(p_mr), .p_jam(p_jam),
		.seen_byte(seen_byte), .seen_mx(seen_mx), .seen_mr(seen_mr)
	);

	// clock
	initial begin
		sys_clk = 1'b0;
		forever #2.5 sys_clk = ~sys_clk;
	end

	task automatic summarize();
		$display("checks %0d mismatches %0d", n_checks, fail_count);
		if (fail_count == 0 && n_checks > 0)
			$display("TEST PASSED");
		else
			$display("TEST FAILED");
		$finish;
	endtask

	task automatic check(input logic [7:0] got, input logic [7:0] exp);
		n_checks++;
		if (got !== exp) begin
			$display("unexpected at %0t: got %h expected %h", $time, got, exp);
			fail_count++;
		end
	endtask

	function automatic logic [31:0] lfsr_next(input logic [31:0] s);
		return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
	endfunction

	task automatic rnd(output logic [7:0] b);
		lfsr_q = lfsr_next(lfsr_q);
		b = lfsr_q[7:0];
	endtask

	// register bus master
	task automatic wr(input logic [2:0] a, input logic [7:0] d);
		@(posedge sys_clk);
		addr <= a;
		wr_data <= d;
		wr_en <= 1'b1;
		@(posedge sys_clk);
		wr_en <= 1'b0;
	endtask

	task automatic rd(input logic [2:0] a, input logic [7:0] e, input logic [7:0] m);
		@(posedge sys_clk);
		addr <= a;
		rd_en <= 1'b1;
		exp_q.push_back({e, m});
		@(posedge sys_clk);
		rd_en <= 1'b0;
	endtask

	task automatic fr(input int n);
		repeat (n) @(posedge fsc);
		@(posedge sys_clk);
	endtask

	// wait up to four frames for a handshake level seen by the partner
	task automatic await(input logic mr, input logic lvl);
		int k;
		for (k = 0; k < 4 && ((mr ? seen_mr : seen_mx) !== lvl); k++)
			fr(1);
	endtask

	// read data checked in the cycle after the strobe
	always @(posedge sys_clk) rd_seen <= rd_en;
	always @(negedge sys_clk) begin
		if (rd_seen === 1'b1) begin
			note = exp_q.pop_front();
			check(rd_data & note[7:0], note[15:8] & note[7:0]);
		end
	end

	// sticky watch of upstream drive, hang guard
	always @(posedge sys_clk) begin
		if (du_oe === 1'b1)
			du_hit <= 1'b1;
		if ((du_oe | dd_oe) === 1'b1)
			check({6'h00, du_out, dd_out}, 8'h00);
		cycles++;
		if (cycles == 70000) begin
			fail_count++;
			summarize();
		end
	end

	initial begin
		logic [7:0] b;
		srst = 1'b1;
		addr = 3'h0;
		wr_data = 8'h00;
		wr_en = 1'b0;
		rd_en = 1'b0;
		rd_seen = 1'b0;
		du_hit = 1'b0;
		p_byte = 8'hFF;
		p_mx = 1'b1;
		p_mr = 1'b1;
		p_jam = 1'b0;
		lfsr_q = 32'h7DFC;
		repeat (6) @(posedge sys_clk);
		srst <= 1'b0;
		rd(ADDR_CTRL, CTRL_RST, 8'hFF);
		rd(ADDR_HS, HS_RST, 8'hFF);
		rd(ADDR_STAT, 8'h00, 8'hFF);
		rd(ADDR_STATE, 8'h00, 8'hFF);
		rd(3'h7, 8'h00, 8'hFF);
		wr(ADDR_CFG, 8'hFF);
		rd(ADDR_CFG, CFG_MASK, 8'hFF);
		wr(ADDR_CFG, CFG_RST);
		$display("test registers done");
		// transmit, acknowledge, new byte, receiver abort
		rnd(b);
		wr(ADDR_TXB, b);
		wr(ADDR_HS, 8'h03);
		fr(3);
		check({7'h00, seen_mx}, 8'h00);
		check(seen_byte, b);
		fr(1);
		check(seen_byte, b);
		rd(ADDR_STATE, 8'h01, 8'h01);
		p_mr <= 1'b0;
		fr(2);
		rd(ADDR_STAT, 8'h01, 8'h0F);
		rnd(b);
		wr(ADDR_TXB, b);
		await(1'b0, 1'b1);
		check(seen_byte, b);
		fr(1);
		check({7'h00, seen_mx}, 8'h00);
		p_mr <= 1'b1;
		fr(3);
		check({7'h00, seen_mx}, 8'h01);
		rd(ADDR_STAT, 8'h02, 8'h02);
		wr(ADDR_HS, 8'h00);
		fr(2);
		rd(ADDR_STATE, 8'h00, 8'h01);
		$display("test transmit done");
		// receive with double look, acknowledge, end of reception
		wr(ADDR_HS, 8'h0A);
		rnd(b);
		p_byte <= b;
		p_mx <= 1'b0;
		fr(1);
		rd(ADDR_STAT, 8'h00, 8'h04);
		fr(2);
		rd(ADDR_STAT, 8'h04, 8'h04);
		rd(ADDR_RXB, b, 8'hFF);
		wr(ADDR_HS, 8'h0E);
		fr(2);
		check({7'h00, seen_mr}, 8'h00);
		rnd(b);
		p_byte <= b;
		p_mx <= 1'b1;
		fr(1);
		p_mx <= 1'b0;
		fr(3);
		rd(ADDR_STAT, 8'h04, 8'h04);
		rd(ADDR_RXB, b, 8'hFF);
		await(1'b1, 1'b1);
		check({7'h00, seen_mr}, 8'h01);
		fr(1);
		check({7'h00, seen_mr}, 8'h00);
		p_mx <= 1'b1;
		p_byte <= 8'hFF;
		fr(3);
		rd(ADDR_STAT, 8'h08, 8'h08);
		wr(ADDR_HS, 8'h00);
		$display("test receive done");
		// channel, enable and port selection
		check({7'h00, du_hit}, 8'h00);
		rnd(b);
		wr(ADDR_CTRL, 8'h09);
		wr(ADDR_TXB, b);
		wr(ADDR_HS, 8'h03);
		fr(3);
		check({7'h00, seen_mx}, 8'h01);
		check(seen_byte, 8'hFF);
		wr(ADDR_CTRL, 8'h08);
		fr(3);
		check(seen_byte, b);
		wr(ADDR_CTRL, 8'h00);
		fr(2);
		check({7'h00, seen_mx}, 8'h01);
		wr(ADDR_CTRL, 8'h0C);
		fr(2);
		check({7'h00, du_hit}, 8'h01);
		wr(ADDR_HS, 8'h00);
		wr(ADDR_CTRL, CTRL_RST);
		fr(3);
		rd(ADDR_STAT, 8'h00, 8'h0F);
		$display("test selection done");
		// collision on a driven data bit
		p_jam <= 1'b1;
		rnd(b);
		wr(ADDR_TXB, b | 8'h80);
		wr(ADDR_HS, 8'h03);
		fr(3);
		rd(ADDR_STAT, 8'h02, 8'h02);
		p_jam <= 1'b0;
		fr(1);
		$display("test collision done");
		summarize();
	end
endmodule
`default_nettype wire
